// ===== logic/hwmon_status_two.sv
// How it works
// RULE1: Status register returns to zero on rising main supply power good.
// RULE2: Writing one clears a bit only once its event ended; zero does nothing.
// RULE3: Fan slow flags bits 2..4 set when tach reading exceeds its minimum.
// RULE4: With start and a diode fault, diode reading forced to 80h.
// RULE5: Diode fault flags bits 6 and 7 set on short or open diode.
// RULE6: Flags stay set until written one or individual enable cleared.
// RULE7: Diode fault flag ignores write-one clears while fault persists.
// RULE8: No flag sets when start or its enable is zero.
// RULE9: Enable cleared while start is one clears the flag at once.
// RULE10: Enable cleared while start zero waits; flag clears when start rises.
// RULE11: Start rising with enable zero clears flag; with enable one no change.
// RULE12: Group enables and global interrupt gate never touch flags.
// RULE13: Fan flags gated by register 80h, diode flags by register 82h.
// RULE14: Read-only bit 0 shows 12V reading out of its limits while start is one.
// RULE15: Reserved bits read zero and ignore writes.
// RULE16: Summary flag set while any flag here is set.
module hwmon_status_two #(
  parameter int FLAG_W = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        main_supply_power_good,
  input  wire logic        volt12_out_of_limit,
  input  wire logic [2:0]  fan_slow_event,
  input  wire logic        diode_one_fault,
  input  wire logic        diode_two_fault,
  input  wire logic [7:0]  diode_one_meas,
  input  wire logic [7:0]  diode_two_meas,
  output logic      [7:0]  diode_one_reading,
  output logic      [7:0]  diode_two_reading,
  output logic             second_group_summary_flag,
  output logic             global_irq_gate,
  output logic             irq
);

  // ------------------------------------------------------------
  // Pin synchronisers (three stages, second and third agree)
  // ------------------------------------------------------------
  logic [6:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  logic [6:0] pin_raw;
  assign pin_raw = {diode_two_fault, diode_one_fault, fan_slow_event,
                    volt12_out_of_limit, main_supply_power_good};

  // Sync chain and agreement filter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
      pin_s3_q <= 7'h00;
      pin_q    <= 7'h00;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < 7; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  logic       pgood, pgood_prev_q, pgood_rise;
  logic       v12_evt;
  logic [2:0] fan_evt;
  logic [1:0] diode_evt;
  assign pgood     = pin_q[0];
  assign v12_evt   = pin_q[1];
  assign fan_evt   = pin_q[4:2];
  assign diode_evt = pin_q[6:5];
  // RULE1 power good edge
  assign pgood_rise = pgood & ~pgood_prev_q;

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [7:0] fan_en_q, temp_en_q, ctrl_q;
  logic [2:0] irq_sts_q, irq_mask_q;
  logic       start_prev_q;
  logic [7:0] status_q;

  logic       wr_acc;
  logic [7:0] wbyte, reg_idx;
  assign wr_acc  = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign wbyte   = avs_writedata[7:0];
  assign reg_idx = avs_address[9:2];

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] ref_idx);
    return idx == ref_idx;
  endfunction

  // Software writable configuration
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fan_en_q   <= hwmon_status_two_pkg::ENABLE_RST;
      temp_en_q  <= hwmon_status_two_pkg::ENABLE_RST;
      ctrl_q     <= hwmon_status_two_pkg::ENABLE_RST;
      irq_mask_q <= hwmon_status_two_pkg::IRQ_RST;
    end else if (wr_acc) begin
      if (hit(reg_idx, hwmon_status_two_pkg::IDX_FAN_ENABLE)) fan_en_q <= wbyte;
      if (hit(reg_idx, hwmon_status_two_pkg::IDX_TEMP_ENABLE)) temp_en_q <= wbyte;
      if (hit(reg_idx, hwmon_status_two_pkg::IDX_CONTROL)) ctrl_q <= {4'h0, wbyte[3:0]};
      if (hit(reg_idx, hwmon_status_two_pkg::IDX_IRQ_MASK)) irq_mask_q <= wbyte[2:0];
    end
  end

  logic start;
  assign start = ctrl_q[hwmon_status_two_pkg::BIT_START];

  // ------------------------------------------------------------
  // Status flag logic
  // ------------------------------------------------------------
  // RULE13 enable mapping per flag
  logic [7:0] flag_en, flag_evt, flag_wc, wc_req;
  always_comb begin
    flag_en = 8'h00;
    flag_en[hwmon_status_two_pkg::BIT_12V] = 1'b1;
    flag_en[hwmon_status_two_pkg::BIT_FAN_THREE:hwmon_status_two_pkg::BIT_FAN_ONE] =
      fan_en_q[hwmon_status_two_pkg::FAN_EN_LSB +: 3];
    flag_en[hwmon_status_two_pkg::BIT_DIODE_ONE] = temp_en_q[hwmon_status_two_pkg::DIODE1_EN_BIT];
    flag_en[hwmon_status_two_pkg::BIT_DIODE_TWO] = temp_en_q[hwmon_status_two_pkg::DIODE2_EN_BIT];
    flag_evt = 8'h00;
    flag_evt[hwmon_status_two_pkg::BIT_12V] = v12_evt;
    // RULE3 fan slow events
    flag_evt[hwmon_status_two_pkg::BIT_FAN_THREE:hwmon_status_two_pkg::BIT_FAN_ONE] = fan_evt;
    // RULE5 diode short or open
    flag_evt[hwmon_status_two_pkg::BIT_DIODE_ONE] = diode_evt[0];
    flag_evt[hwmon_status_two_pkg::BIT_DIODE_TWO] = diode_evt[1];
  end

  // RULE2 RULE7 RULE15 write one clears ended events only
  assign wc_req  = (wr_acc && hit(reg_idx, hwmon_status_two_pkg::IDX_STATUS_TWO)) ?
                   (wbyte & hwmon_status_two_pkg::STATUS_WMASK) : 8'h00;
  assign flag_wc = wc_req & ~flag_evt;

  logic       start_rise;
  logic [7:0] status_d;
  assign start_rise = start & ~start_prev_q;

  // Next status value, set wins over clear
  always_comb begin
    status_d = status_q;
    // RULE6 sticky hold, write clear
    status_d = status_d & ~flag_wc;
    // RULE9 RULE10 RULE11 enable clear only with start
    if (start) begin
      status_d = status_d & flag_en;
    end
    // RULE8 set only with start and enable
    if (start) begin
      status_d = status_d | (flag_evt & flag_en);
    end
    // RULE14 12V bit is a read-only live indication
    status_d[hwmon_status_two_pkg::BIT_12V] = start & v12_evt;
    status_d[1] = 1'b0;
    status_d[5] = 1'b0;
  end

  // Status register, cleared on power good rise
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_q     <= hwmon_status_two_pkg::STATUS_RST;
      pgood_prev_q <= 1'b0;
      start_prev_q <= 1'b0;
    end else begin
      pgood_prev_q <= pgood;
      start_prev_q <= start;
      // RULE1 reset on power good rise
      if (pgood_rise) begin
        status_q <= hwmon_status_two_pkg::STATUS_RST;
      end else begin
        status_q <= status_d;
      end
    end
  end

  // ------------------------------------------------------------
  // Readings and outputs
  // ------------------------------------------------------------
  // Diode readings, forced on fault while started
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      diode_one_reading <= 8'h00;
      diode_two_reading <= 8'h00;
    end else begin
      // RULE4 force fault reading
      diode_one_reading <= (start && diode_evt[0]) ?
                           hwmon_status_two_pkg::DIODE_FORCE : diode_one_meas;
      diode_two_reading <= (start && diode_evt[1]) ?
                           hwmon_status_two_pkg::DIODE_FORCE : diode_two_meas;
    end
  end

  // Summary and gate outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      second_group_summary_flag <= 1'b0;
      global_irq_gate           <= 1'b0;
    end else begin
      // RULE16 summary follows flags
      second_group_summary_flag <= |status_d & ~pgood_rise;
      // RULE12 gate only drives outward
      global_irq_gate <= ctrl_q[hwmon_status_two_pkg::BIT_IRQ_GATE];
    end
  end

  // ------------------------------------------------------------
  // Block interrupt: sticky events, W1C, masked level
  // ------------------------------------------------------------
  logic [2:0] irq_evt, irq_wc;
  logic [7:0] new_set;
  assign new_set = status_d & ~status_q;
  assign irq_evt = {|new_set[7:6], |new_set[4:2], new_set[0]};
  assign irq_wc  = (wr_acc && hit(reg_idx, hwmon_status_two_pkg::IDX_IRQ_STATUS)) ?
                   wbyte[2:0] : 3'h0;

  // Sticky interrupt status
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_sts_q <= hwmon_status_two_pkg::IRQ_RST;
      irq       <= 1'b0;
    end else begin
      irq_sts_q <= (irq_sts_q & ~irq_wc) | irq_evt;
      irq       <= |(((irq_sts_q & ~irq_wc) | irq_evt) & irq_mask_q);
    end
  end

  // ------------------------------------------------------------
  // Avalon slave: one wait cycle, then answer
  // ------------------------------------------------------------
  logic [7:0] rd_val;
  // Read mux by word index
  always_comb begin
    case (reg_idx)
      hwmon_status_two_pkg::IDX_STATUS_TWO:  rd_val = status_q;
      hwmon_status_two_pkg::IDX_FAN_ENABLE:  rd_val = fan_en_q;
      hwmon_status_two_pkg::IDX_TEMP_ENABLE: rd_val = temp_en_q;
      hwmon_status_two_pkg::IDX_CONTROL:     rd_val = ctrl_q;
      hwmon_status_two_pkg::IDX_IRQ_STATUS:  rd_val = {5'h00, irq_sts_q};
      hwmon_status_two_pkg::IDX_IRQ_MASK:    rd_val = {5'h00, irq_mask_q};
      hwmon_status_two_pkg::IDX_DIODE_ONE:   rd_val = diode_one_reading;
      hwmon_status_two_pkg::IDX_DIODE_TWO:   rd_val = diode_two_reading;
      default:                               rd_val = 8'h00;
    endcase
  end

  // Waitrequest drops one cycle after a request
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if ((avs_read | avs_write) & avs_waitrequest) begin
        avs_readdata <= {24'h000000, rd_val};
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_pgood_clears: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE1
    pgood_rise |=> status_q == 8'h00) else $error("status not cleared on power good");
  a_wc_blocked: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE7
    status_q[7] && diode_evt[1] && !pgood_rise &&
    !(start && !flag_en[hwmon_status_two_pkg::BIT_DIODE_TWO]) |=> status_q[7])
    else $error("diode two flag lost during fault");
  a_no_set_stopped: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE8
    !start && !status_q[2] && !pgood_rise |=> !status_q[2])
    else $error("fan flag set while stopped");
  a_en_clear_now: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9
    start && !flag_en[3] |=> !status_q[3]) else $error("flag kept with enable off");
  a_hold_stopped: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE10
    !start && status_q[2] && !wc_req[2] && !pgood_rise |=> status_q[2])
    else $error("flag lost while stopped");
  // Fan flag gone after a granted write one
  a_fan_w1c: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2
    flag_wc[2] && !pgood_rise |=> !status_q[2])
    else $error("fan one flag kept after clear");
  a_fan_set: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
    start && fan_evt[0] && fan_en_q[2] && !pgood_rise |=> status_q[2])
    else $error("fan one flag not set");
  a_diode_force: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
    start && diode_evt[0] |=> diode_one_reading == 8'h80) else $error("reading not forced");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE15
    status_q[1] == 1'b0 && status_q[5] == 1'b0) else $error("reserved bit set");
  a_summary_link: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE16
    second_group_summary_flag == (|status_q)) else $error("summary mismatch");
  c_fan_set: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(status_q[2]));
  c_diode_wc: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(status_q[6]));
  c_start_rise: cover property (@(posedge sys_clk) disable iff (!rstn) start_rise);
  c_irq: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(irq));

endmodule

// ===== logic/hwmon_status_two_pkg.sv
package hwmon_status_two_pkg;

  // ------------------------------------------------------------
  // Register map (word indices; byte address is word index times four)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS_TWO  = 8'h42;
  localparam logic [7:0] IDX_FAN_ENABLE  = 8'h80;
  localparam logic [7:0] IDX_TEMP_ENABLE = 8'h82;
  localparam logic [7:0] IDX_CONTROL     = 8'hc0;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'hc1;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'hc2;
  localparam logic [7:0] IDX_DIODE_ONE   = 8'hc3;
  localparam logic [7:0] IDX_DIODE_TWO   = 8'hc4;
  localparam int         ADDR_W          = 10;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_12V       = 0;
  localparam int BIT_FAN_ONE   = 2;
  localparam int BIT_FAN_TWO   = 3;
  localparam int BIT_FAN_THREE = 4;
  localparam int BIT_DIODE_ONE = 6;
  localparam int BIT_DIODE_TWO = 7;
  localparam int BIT_START     = 0;
  localparam int BIT_FAN_GROUP = 1;
  localparam int BIT_TEMP_GRP  = 2;
  localparam int BIT_IRQ_GATE  = 3;
  // Fan enables in bits 2..4 of the fan enable register
  localparam int FAN_EN_LSB    = 2;
  // Diode limit error enables: bit 0 diode one, bit 2 diode two
  localparam int DIODE1_EN_BIT = 0;
  localparam int DIODE2_EN_BIT = 2;

  // ------------------------------------------------------------
  // Reset values and constants
  // ------------------------------------------------------------
  localparam logic [7:0] STATUS_RST     = 8'h00;
  localparam logic [7:0] STATUS_WMASK   = 8'hdc;
  localparam logic [7:0] ENABLE_RST     = 8'h00;
  localparam logic [7:0] DIODE_FORCE    = 8'h80;
  localparam logic [2:0] IRQ_RST        = 3'h0;

endpackage

// ===== sim/test_hwmon_status_two.sv
module test_hwmon_status_two;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Addresses and signals
  // ----------------------------------------
  localparam logic [9:0] A_ST  = {hwmon_status_two_pkg::IDX_STATUS_TWO, 2'b00};
  localparam logic [9:0] A_FEN = {hwmon_status_two_pkg::IDX_FAN_ENABLE, 2'b00};
  localparam logic [9:0] A_TEN = {hwmon_status_two_pkg::IDX_TEMP_ENABLE, 2'b00};
  localparam logic [9:0] A_CTL = {hwmon_status_two_pkg::IDX_CONTROL, 2'b00};
  localparam logic [9:0] A_IST = {hwmon_status_two_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] A_IMK = {hwmon_status_two_pkg::IDX_IRQ_MASK, 2'b00};
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [9:0]  avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0]  avs_byteenable = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        main_supply_power_good = 1'b1;
  logic        volt12_out_of_limit = 1'b0;
  logic [2:0]  fan_slow_event = '0;
  logic        diode_one_fault = 1'b0;
  logic        diode_two_fault = 1'b0;
  logic [7:0]  diode_one_meas = '0;
  logic [7:0]  diode_two_meas = '0;
  logic [7:0]  diode_one_reading;
  logic [7:0]  diode_two_reading;
  logic        second_group_summary_flag;
  logic        global_irq_gate;
  logic        irq;
  int          fail_count = 0;
  int          checks = 0;
  logic [31:0] seed = 32'h470fa7b7;
  logic [7:0]  q;
  logic [7:0]  e;
  logic [31:0] r;

  hwmon_status_two i_hwmon_status_two (
    .sys_clk                   (sys_clk),
    .rstn                      (rstn),
    .avs_address               (avs_address),
    .avs_read                  (avs_read),
    .avs_write                 (avs_write),
    .avs_writedata             (avs_writedata),
    .avs_byteenable            (avs_byteenable),
    .avs_readdata              (avs_readdata),
    .avs_waitrequest           (avs_waitrequest),
    .main_supply_power_good    (main_supply_power_good),
    .volt12_out_of_limit       (volt12_out_of_limit),
    .fan_slow_event            (fan_slow_event),
    .diode_one_fault           (diode_one_fault),
    .diode_two_fault           (diode_two_fault),
    .diode_one_meas            (diode_one_meas),
    .diode_two_meas            (diode_two_meas),
    .diode_one_reading         (diode_one_reading),
    .diode_two_reading         (diode_two_reading),
    .second_group_summary_flag (second_group_summary_flag),
    .global_irq_gate           (global_irq_gate),
    .irq                       (irq)
  );

  // Clock, 25 ns period
  always #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected status with start high
  function automatic logic [7:0] exp_st(input logic [31:0] s, input logic [7:0] fe,
                                        input logic [7:0] te);
    return {s[3] & te[2], s[2] & te[0], 1'b0, s[6:4] & fe[4:2], 1'b0, s[0]};
  endfunction

  task automatic chk8(input string n, input logic [7:0] x, input logic [7:0] g);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic chk1(input string n, input logic x, input logic g);
    chk8(n, {7'h0, x}, {7'h0, g});
  endtask

  // One bus access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= 4'h1;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input string n, input logic [7:0] x);
    acc(1'b0, a, 8'h00);
    chk8(n, x, q);
  endtask

  // Pin levels; wait past the input synchronisers
  task automatic pins(input logic [31:0] s);
    @(posedge sys_clk);
    volt12_out_of_limit <= s[0];
    diode_one_fault <= s[2];
    diode_two_fault <= s[3];
    fan_slow_event <= s[6:4];
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    wrap_up();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    chk1("waitrequest", 1'b1, avs_waitrequest);
    rd(A_ST, "status reset", 8'h00); // reset
    rd(10'h3fc, "unmapped", 8'h00);
    acc(1'b1, A_FEN, 8'h1c);
    acc(1'b1, A_TEN, 8'h05);
    pins(32'h7d);
    rd(A_ST, "status stopped", 8'h00); // no set
    acc(1'b1, A_CTL, 8'h0f);
    repeat (8) @(posedge sys_clk);
    rd(A_ST, "status set", 8'hdd);
    chk1("gate", 1'b1, global_irq_gate);
    chk8("diode one forced", 8'h80, diode_one_reading); // forced
    chk8("diode two forced", 8'h80, diode_two_reading); // forced
    rd(A_IST, "irq status", 8'h07);
    acc(1'b1, A_IMK, 8'h07);
    rd(A_IMK, "irq mask", 8'h07);
    chk1("irq on", 1'b1, irq);
    acc(1'b1, A_IMK, 8'h00);
    rd(A_IMK, "irq mask", 8'h00);
    chk1("irq masked", 1'b0, irq);
    pins(32'h0d);
    rd(A_ST, "status sticky", 8'hdd); // sticky
    acc(1'b1, A_ST, 8'hff);
    rd(A_ST, "status w1c", 8'hc1);
    acc(1'b1, A_ST, 8'h00);
    rd(A_ST, "status w0", 8'hc1); // zero
    chk1("summary", 1'b1, second_group_summary_flag); // summary
    acc(1'b1, A_CTL, 8'h01);
    rd(A_ST, "status groups off", 8'hc1); // groups
    chk1("gate", 1'b0, global_irq_gate);
    acc(1'b1, A_TEN, 8'h00);
    rd(A_ST, "status enable off", 8'h01);
    pins(32'h1d);
    rd(A_ST, "status fan one", 8'h05); // fan one
    pins(32'h01);
    acc(1'b1, A_CTL, 8'h00);
    rd(A_ST, "status start off", 8'h04); // enable high
    acc(1'b1, A_FEN, 8'h00);
    rd(A_ST, "status held", 8'h04); // held
    acc(1'b1, A_CTL, 8'h01);
    rd(A_ST, "status start on", 8'h01);
    // Random events and enables, then clear
    repeat (12) begin
      r = rnd();
      acc(1'b1, A_FEN, r[15:8] & 8'h1c);
      acc(1'b1, A_TEN, r[23:16] & 8'h05);
      diode_one_meas <= r[31:24];
      diode_two_meas <= r[23:16];
      pins(r);
      e = exp_st(r, r[15:8], r[23:16]);
      rd(A_ST, "status random", e);
      chk1("summary", |e, second_group_summary_flag); // summary
      chk8("diode one", r[2] ? 8'h80 : r[31:24], diode_one_reading); // reading
      chk8("diode two", r[3] ? 8'h80 : r[23:16], diode_two_reading); // reading
      rd({hwmon_status_two_pkg::IDX_DIODE_ONE, 2'b00}, "diode one reg", r[2] ? 8'h80 : r[31:24]);
      pins(32'h0);
      acc(1'b1, A_ST, 8'hff);
      rd(A_ST, "status cleared", 8'h00); // cleared
      chk1("summary", 1'b0, second_group_summary_flag); // cleared
    end
    acc(1'b1, A_IMK, 8'h07);
    acc(1'b1, A_IST, 8'h07);
    rd(A_IST, "irq status", 8'h00);
    chk1("irq cleared", 1'b0, irq);
    acc(1'b1, A_FEN, 8'h1c);
    pins(32'h70);
    pins(32'h00);
    rd(A_ST, "status fans", 8'h1c); // sticky
    @(posedge sys_clk);
    main_supply_power_good <= 1'b0;
    repeat (8) @(posedge sys_clk);
    main_supply_power_good <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd(A_ST, "status power good", 8'h00); // power good
    wrap_up();
  end
endmodule
